// >>> rtl/ts_seq_regs.svh
// register offsets, field positions, reset values and timing figures of the signal sequencer
`ifndef TS_SEQ_REGS_SVH
`define TS_SEQ_REGS_SVH

`define TS_CTRL_OFS 8'h00
`define TS_STATUS_OFS 8'h04
`define TS_IRQ_STAT_OFS 8'h08
`define TS_IRQ_MASK_OFS 8'h0C

`define TS_CTRL_PAT_LSB 0
`define TS_CTRL_FLASH_BIT 2
`define TS_CTRL_RST 3'h0
`define TS_MASK_RST 4'h0

`define TS_ST_STEP_LSB 0
`define TS_ST_STATE_LSB 3
`define TS_ST_PAT_LSB 7
`define TS_ST_MANUAL_BIT 9
`define TS_ST_GG_BIT 10
`define TS_ST_FAIL_BIT 11

`define TS_IRQ_GG_BIT 0
`define TS_IRQ_FAIL_BIT 1
`define TS_IRQ_FLASH_BIT 2
`define TS_IRQ_STEP_BIT 3

`define TS_RESP_OKAY 2'h0
`define TS_RESP_SLVERR 2'h2
`define TS_SCHED_FLASH 2'h3

`define TS_CLK_NS 8
`define TS_CS_NS 10000000
`define TS_MS_PER_CS 10
`define TS_SEC_CS 100
`define TS_ALLRED_MS 5000
`define TS_FLASH_MS 1000
`define TS_MIN_SHORT_MS 950
`define TS_MIN_MID_MS 950
`define TS_MIN_LONG_MS 8000
`define TS_MAX_SHORT_MS 35000
`define TS_MAX_MID_MS 110000
`define TS_MAX_LONG_MS 110000

`endif

// >>> rtl/ts_seq_pkg.sv
// types and step table of the signal sequencer
package ts_seq_pkg;

  typedef struct packed {
    logic arrow;
    logic ped_red;
    logic ped_grn;
    logic red;
    logic amber;
    logic green;
  } ts_lamp_t;

  // phases 0 and 1 are major road, 2 and 3 minor road
  typedef ts_lamp_t [3:0] ts_lamps_t;

  typedef enum logic [3:0] {
    TS_ALLRED = 4'h1,
    TS_RUN = 4'h2,
    TS_FLASH = 4'h4,
    TS_FAULT = 4'h8
  } ts_state_t;

  typedef enum logic [1:0] {
    TS_SHORT = 2'h0,
    TS_MIDDLE = 2'h1,
    TS_LONG = 2'h2
  } ts_class_t;

  typedef enum logic [1:0] {
    TS_TIMING_PATTERN_ONE = 2'h0,
    TS_TIMING_PATTERN_TWO = 2'h1,
    TS_TIMING_PATTERN_THREE = 2'h2
  } ts_pat_t;

  typedef struct packed {
    ts_lamps_t lamps;
    ts_class_t cls;
    logic [6:0] secs;
    logic [2:0] slot;
  } ts_step_t;

  localparam logic [2:0] TS_SHARED = 3'h7;
  localparam logic [5:0] VG_PR = 6'h11;
  localparam logic [5:0] VA_PR = 6'h12;
  localparam logic [5:0] VR_PR = 6'h14;
  localparam logic [5:0] VR_PG = 6'h0C;
  localparam logic [5:0] VR_AR = 6'h34;

  // seconds of the five pattern-dependent steps, per timing pattern
  localparam logic [6:0] TS_PAT_SECS [3][5] = '{
    '{7'h1E, 7'h02, 7'h14, 7'h02, 7'h0A},
    '{7'h2D, 7'h03, 7'h19, 7'h03, 7'h0C},
    '{7'h3C, 7'h03, 7'h23, 7'h03, 7'h0F}
  };

  function automatic ts_step_t ts_step_row(input logic [2:0] idx);
    ts_step_t r;
    r = '0;
    case (idx)
      3'h0: r = '{lamps: {VR_PG, VR_PG, VG_PR, VG_PR}, cls: TS_LONG, secs: 7'h00, slot: 3'h0};
      3'h1: r = '{lamps: {VR_PR, VR_PR, VA_PR, VA_PR}, cls: TS_SHORT, secs: 7'h03, slot: TS_SHARED};
      3'h2: r = '{lamps: {VR_PR, VR_PR, VR_PR, VR_PR}, cls: TS_SHORT, secs: 7'h00, slot: 3'h1};
      3'h3: r = '{lamps: {VG_PR, VG_PR, VR_PG, VR_PG}, cls: TS_LONG, secs: 7'h00, slot: 3'h2};
      3'h4: r = '{lamps: {VA_PR, VA_PR, VR_PR, VR_PR}, cls: TS_SHORT, secs: 7'h03, slot: TS_SHARED};
      3'h5: r = '{lamps: {VR_PR, VR_PR, VR_PR, VR_PR}, cls: TS_SHORT, secs: 7'h00, slot: 3'h3};
      3'h6: r = '{lamps: {VR_PR, VR_PR, VR_AR, VR_AR}, cls: TS_MIDDLE, secs: 7'h00, slot: 3'h4};
      default: r = '{lamps: {VR_PR, VR_PR, VR_PR, VR_PR}, cls: TS_SHORT, secs: 7'h02, slot: TS_SHARED};
    endcase
    return r;
  endfunction

endpackage

// >>> rtl/ts_seq_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ts_seq_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  // output follows only bits where stage two and three agree
  always_comb begin
    nxt_q = (q_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

// >>> rtl/ts_seq_top.sv
// signal step sequencer with flashing, manual and multi-pattern modes and an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ts_seq_regs.svh"
// What this block does
// - flashing alternates major amber with minor red
// - flashing keeps pedestrian and arrow lamps dark
// - time-switch flash selection enters flashing
// - panel flash switch enters flashing
// - over-long step enters abnormal flashing
// - crossing greens enter abnormal flashing
// - manual button advances exactly one step
// - manual mode holds step without timeout
// - three patterns set five step times, patterns two and three differ in three of them
// - start: five seconds all red, then step one
// - steps honour class minimum times, and class maximum times outside manual mode
// - abnormal flashing holds until reset button
// - priority: flashing, then manual, then automatic
module ts_seq_top #(
  parameter int unsigned CS_CYC = `TS_CS_NS / `TS_CLK_NS,
  parameter int unsigned FLASH_CS = `TS_FLASH_MS / `TS_MS_PER_CS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] sched_sel,
  input wire logic flash_sw,
  input wire logic manual_sel,
  input wire logic manual_btn,
  input wire logic reset_btn,
  input wire logic [3:0] green_sense,
  output ts_seq_pkg::ts_lamps_t lamps,
  output logic [2:0] step_num,
  output logic gg_lamp,
  output logic fail_lamp,
  output logic irq
);
  logic [9:0] syn, syn_d_ff;
  logic [1:0] s_sched;
  logic s_flash, s_man, press_man, press_rst, gg_conf, flash_req;
  ts_seq_pkg::ts_step_t row;
  logic [13:0] dur_cs, min_cs, max_cs;
  logic [6:0] secs;
  ts_seq_pkg::ts_state_t state_ff, nxt_state;
  logic [2:0] step_ff, nxt_step;
  logic [1:0] pat_ff, nxt_pat, pat_pick;
  logic [13:0] el_ff, nxt_el, fl_ff, nxt_fl;
  logic [20:0] cs_ff, nxt_cs;
  logic ph_ff, nxt_ph, gg_ff, nxt_gg, fail_ff, nxt_fail, tick;
  ts_seq_pkg::ts_lamps_t lamps_ff, nxt_lamps;
  logic [3:0] ev_set;
  logic [2:0] ctrl_ff, nxt_ctrl;
  logic [3:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rdata_ff, nxt_rdata;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic do_wr, do_rd, stat_rd;

  ts_seq_sync #(.W(10)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({green_sense, reset_btn, manual_btn, manual_sel, flash_sw, sched_sel}),
    .q(syn)
  );

  always_comb begin
    s_sched = syn[1:0];
    s_flash = syn[2];
    s_man = syn[3];
    press_man = syn[4] & ~syn_d_ff[4];
    press_rst = syn[5] & ~syn_d_ff[5];
    gg_conf = (|syn[7:6]) & (|syn[9:8]);
    flash_req = (s_sched == `TS_SCHED_FLASH) | s_flash | ctrl_ff[`TS_CTRL_FLASH_BIT];
    tick = (cs_ff == 21'(CS_CYC - 1));
    nxt_cs = tick ? 21'h0 : cs_ff + 21'h1;
    // pattern: panel field 0 follows the time switch
    if (ctrl_ff[1:0] == 2'h0) begin
      pat_pick = (s_sched == `TS_SCHED_FLASH) ? 2'h0 : s_sched;
    end else begin
      pat_pick = ctrl_ff[1:0] - 2'h1;
    end
    if (pat_pick == 2'h3) begin
      pat_pick = 2'h0;
    end
    row = ts_seq_pkg::ts_step_row(step_ff);
    secs = (row.slot == ts_seq_pkg::TS_SHARED) ? row.secs : ts_seq_pkg::TS_PAT_SECS[pat_ff][row.slot];
    dur_cs = 14'(int'(secs) * `TS_SEC_CS);
    case (row.cls)
      ts_seq_pkg::TS_SHORT: begin
        min_cs = 14'(`TS_MIN_SHORT_MS / `TS_MS_PER_CS);
        max_cs = 14'(`TS_MAX_SHORT_MS / `TS_MS_PER_CS);
      end
      ts_seq_pkg::TS_MIDDLE: begin
        min_cs = 14'(`TS_MIN_MID_MS / `TS_MS_PER_CS);
        max_cs = 14'(`TS_MAX_MID_MS / `TS_MS_PER_CS);
      end
      default: begin
        min_cs = 14'(`TS_MIN_LONG_MS / `TS_MS_PER_CS);
        max_cs = 14'(`TS_MAX_LONG_MS / `TS_MS_PER_CS);
      end
    endcase
  end

  // mode and step sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_pat = pat_ff;
    nxt_gg = gg_ff;
    nxt_fail = fail_ff;
    nxt_el = (tick && el_ff != 14'h3FFF) ? el_ff + 14'h1 : el_ff;
    ev_set = 4'h0;
    case (state_ff)
      ts_seq_pkg::TS_ALLRED: begin
        if (flash_req) begin
          nxt_state = ts_seq_pkg::TS_FLASH;
        end else if (el_ff >= 14'(`TS_ALLRED_MS / `TS_MS_PER_CS)) begin
          nxt_state = ts_seq_pkg::TS_RUN;
          nxt_step = 3'h0;
          nxt_pat = pat_pick;
          nxt_el = 14'h0;
        end
      end
      ts_seq_pkg::TS_RUN: begin
        if (flash_req) begin
          nxt_state = ts_seq_pkg::TS_FLASH;
        end else if (s_man) begin
          if (press_man && el_ff >= min_cs) begin
            nxt_step = step_ff + 3'h1;
            nxt_el = 14'h0;
          end
        end else if (el_ff >= max_cs) begin
          nxt_state = ts_seq_pkg::TS_FAULT;
          nxt_fail = 1'b1;
        end else if (el_ff >= dur_cs && el_ff >= min_cs) begin
          nxt_step = step_ff + 3'h1;
          nxt_el = 14'h0;
        end
        if (nxt_step != step_ff && nxt_step == 3'h0) begin
          nxt_pat = pat_pick;
        end
      end
      ts_seq_pkg::TS_FLASH: begin
        if (!flash_req) begin
          nxt_state = ts_seq_pkg::TS_RUN;
          nxt_step = 3'h0;
          nxt_pat = pat_pick;
          nxt_el = 14'h0;
        end
      end
      ts_seq_pkg::TS_FAULT: begin
        nxt_state = ts_seq_pkg::TS_FAULT;
      end
      default: begin
        nxt_state = ts_seq_pkg::TS_ALLRED;
      end
    endcase
    if (gg_conf) begin
      nxt_state = ts_seq_pkg::TS_FAULT;
      nxt_gg = 1'b1;
    end else if (press_rst && !gg_conf) begin
      nxt_state = s_flash ? ts_seq_pkg::TS_FLASH : ts_seq_pkg::TS_ALLRED;
      nxt_step = 3'h0;
      nxt_el = 14'h0;
      nxt_gg = 1'b0;
      nxt_fail = 1'b0;
    end
    ev_set[`TS_IRQ_GG_BIT] = nxt_gg & ~gg_ff;
    ev_set[`TS_IRQ_FAIL_BIT] = nxt_fail & ~fail_ff;
    ev_set[`TS_IRQ_FLASH_BIT] = (nxt_state == ts_seq_pkg::TS_FLASH) && (state_ff != ts_seq_pkg::TS_FLASH);
    ev_set[`TS_IRQ_STEP_BIT] = (nxt_state == ts_seq_pkg::TS_RUN) && (nxt_step != step_ff);
    // flash toggle timebase
    nxt_fl = fl_ff;
    nxt_ph = ph_ff;
    if (tick) begin
      if (fl_ff >= 14'(FLASH_CS - 1)) begin
        nxt_fl = 14'h0;
        nxt_ph = ~ph_ff;
      end else begin
        nxt_fl = fl_ff + 14'h1;
      end
    end
    // lamp drive, all outputs dark while flashing except amber and red groups
    nxt_lamps = '0;
    case (state_ff)
      ts_seq_pkg::TS_RUN: begin
        nxt_lamps = row.lamps;
      end
      ts_seq_pkg::TS_FLASH, ts_seq_pkg::TS_FAULT: begin
        nxt_lamps[0].amber = ph_ff;
        nxt_lamps[1].amber = ph_ff;
        nxt_lamps[2].red = ~ph_ff;
        nxt_lamps[3].red = ~ph_ff;
      end
      default: begin
        nxt_lamps = {4{ts_seq_pkg::VR_PR}};
      end
    endcase
  end

  // AXI4-Lite slave and interrupt status
  always_comb begin
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_aw_have = aw_have_ff | (s_axi_awvalid & awready_ff);
    nxt_w_have = w_have_ff | (s_axi_wvalid & wready_ff);
    if (s_axi_awvalid && awready_ff) begin
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wd = s_axi_wdata;
    end
    do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_bresp = bresp_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    if (do_wr) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `TS_RESP_OKAY;
      case (awa_ff[7:2])
        6'(`TS_CTRL_OFS >> 2): begin
          if (s_axi_wstrb[0]) begin
            nxt_ctrl = wd_ff[2:0];
          end
        end
        6'(`TS_IRQ_MASK_OFS >> 2): begin
          if (s_axi_wstrb[0]) begin
            nxt_mask = wd_ff[3:0];
          end
        end
        6'(`TS_STATUS_OFS >> 2), 6'(`TS_IRQ_STAT_OFS >> 2): begin
          nxt_bresp = `TS_RESP_OKAY;
        end
        default: begin
          nxt_bresp = `TS_RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = ~nxt_aw_have & ~nxt_bvalid;
    nxt_wready = ~nxt_w_have & ~nxt_bvalid;
    do_rd = s_axi_arvalid & arready_ff;
    stat_rd = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    if (do_rd) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `TS_RESP_OKAY;
      case (s_axi_araddr[7:2])
        6'(`TS_CTRL_OFS >> 2): nxt_rdata = {29'h0, ctrl_ff};
        6'(`TS_STATUS_OFS >> 2): nxt_rdata = {20'h0, fail_ff, gg_ff, s_man, pat_ff, state_ff, step_ff};
        6'(`TS_IRQ_STAT_OFS >> 2): begin
          nxt_rdata = {28'h0, stat_ff};
          stat_rd = 1'b1;
        end
        6'(`TS_IRQ_MASK_OFS >> 2): nxt_rdata = {28'h0, mask_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `TS_RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = ~nxt_rvalid & ~do_rd;
    // read clears, a same-cycle event still sets
    nxt_stat = (stat_rd ? 4'h0 : stat_ff) | ev_set;
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syn_d_ff <= 10'h000;
      cs_ff <= 21'h0;
      state_ff <= ts_seq_pkg::TS_ALLRED;
      step_ff <= 3'h0;
      pat_ff <= 2'h0;
      el_ff <= 14'h0;
      fl_ff <= 14'h0;
      ph_ff <= 1'b0;
      gg_ff <= 1'b0;
      fail_ff <= 1'b0;
      lamps_ff <= {4{ts_seq_pkg::VR_PR}};
      ctrl_ff <= `TS_CTRL_RST;
      mask_ff <= `TS_MASK_RST;
      stat_ff <= 4'h0;
      irq_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0;
    end else begin
      syn_d_ff <= syn;
      cs_ff <= nxt_cs;
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      pat_ff <= nxt_pat;
      el_ff <= nxt_el;
      fl_ff <= nxt_fl;
      ph_ff <= nxt_ph;
      gg_ff <= nxt_gg;
      fail_ff <= nxt_fail;
      lamps_ff <= nxt_lamps;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign lamps = lamps_ff;
  assign step_num = step_ff;
  assign gg_lamp = gg_ff;
  assign fail_lamp = fail_ff;
  assign irq = irq_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence flashing_s;
    state_ff == ts_seq_pkg::TS_FLASH || state_ff == ts_seq_pkg::TS_FAULT;
  endsequence
  sequence dark_extras_s;
    (lamps_ff & {4{6'h38}}) == 24'h0;
  endsequence

  flash_alternate_a: assert property (flashing_s ##1 flashing_s |-> lamps_ff[0].amber != lamps_ff[2].red)
    else $error("flash groups not alternating");
  flash_dark_a: assert property (flashing_s |=> dark_extras_s)
    else $error("pedestrian or arrow lamp lit while flashing");
  sched_flash_a: assert property (state_ff == ts_seq_pkg::TS_RUN && s_sched == `TS_SCHED_FLASH && !gg_conf
    && !press_rst |=> state_ff == ts_seq_pkg::TS_FLASH)
    else $error("schedule flash not entered");
  panel_flash_a: assert property (state_ff != ts_seq_pkg::TS_FAULT && s_flash && !gg_conf
    |=> state_ff == ts_seq_pkg::TS_FLASH)
    else $error("panel flash not entered");
  step_timeout_a: assert property (state_ff == ts_seq_pkg::TS_RUN && !flash_req && !s_man && el_ff >= max_cs
    && !gg_conf && !press_rst |=> state_ff == ts_seq_pkg::TS_FAULT && fail_ff)
    else $error("step timeout not caught");
  gg_fault_a: assert property (gg_conf |=> state_ff == ts_seq_pkg::TS_FAULT && gg_ff)
    else $error("crossing greens not caught");
  manual_step_a: assert property (state_ff == ts_seq_pkg::TS_RUN && s_man && press_man && el_ff >= min_cs
    && !flash_req && !gg_conf && !press_rst |=> step_ff == $past(step_ff) + 3'h1 && el_ff == 14'h0)
    else $error("manual press did not advance by one");
  manual_hold_a: assert property (state_ff == ts_seq_pkg::TS_RUN && s_man && !press_man && !flash_req
    && !gg_conf && !press_rst |=> $stable(step_ff) && state_ff == ts_seq_pkg::TS_RUN)
    else $error("manual step changed without press");
  allred_start_a: assert property (state_ff == ts_seq_pkg::TS_ALLRED |=> lamps_ff == {4{ts_seq_pkg::VR_PR}})
    else $error("start display not all red");
  min_time_a: assert property (state_ff == ts_seq_pkg::TS_RUN && nxt_state == ts_seq_pkg::TS_RUN
    && nxt_step != step_ff |-> el_ff >= min_cs)
    else $error("step left before minimum time");
  fault_hold_a: assert property (state_ff == ts_seq_pkg::TS_FAULT && !press_rst |=> state_ff == ts_seq_pkg::TS_FAULT)
    else $error("abnormal flashing left without reset");
  irq_level_a: assert property (##1 irq == |(stat_ff & mask_ff))
    else $error("interrupt does not follow masked status");
endmodule

// >>> sim/ts_seq_panel.sv
// far-side model: lamp monitors feeding green sense, with injectable stray greens
`timescale 1ns/10ps
module ts_seq_panel (
  input wire ts_seq_pkg::ts_lamps_t lamps,
  input wire logic [3:0] fault,
  output logic [3:0] green_sense
);
  // a monitor reports lit while the green drive is on or a stray green is injected
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      green_sense[i] = lamps[i].green | fault[i];
    end
  end
endmodule

// >>> sim/traffic_signal_sequencer_tb_top.sv
// self-checking bench of the signal step sequencer
`timescale 1ns/10ps
`include "ts_seq_regs.svh"
module traffic_signal_sequencer_tb_top;
  localparam int CS = 4;
  localparam int FL = 2;
  typedef struct packed {
    logic [1:0] sched;
    logic fsw;
    logic man;
    logic [2:0] ctrl;
    logic [3:0] state;
  } ts_row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0] bresp, rresp, rr, sched_sel;
  logic flash_sw, manual_sel, manual_btn, reset_btn, gg_lamp, fail_lamp, irq;
  logic [3:0] green_sense, fault;
  logic [2:0] step_num;
  ts_seq_pkg::ts_lamps_t lamps;
  int bad_count, checks;
  ts_row_t rows [5] = '{'{2'h3, 1'b0, 1'b0, 3'h0, 4'h4}, '{2'h0, 1'b1, 1'b0, 3'h0, 4'h4},
    '{2'h0, 1'b1, 1'b1, 3'h0, 4'h4}, '{2'h0, 1'b0, 1'b0, 3'h4, 4'h4}, '{2'h0, 1'b0, 1'b1, 3'h0, 4'h2}};

  ts_seq_top #(.CS_CYC(CS), .FLASH_CS(FL)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sched_sel(sched_sel), .flash_sw(flash_sw), .manual_sel(manual_sel),
    .manual_btn(manual_btn), .reset_btn(reset_btn), .green_sense(green_sense), .lamps(lamps),
    .step_num(step_num), .gg_lamp(gg_lamp), .fail_lamp(fail_lamp), .irq(irq));

  ts_seq_panel u_panel (.lamps(lamps), .fault(fault), .green_sense(green_sense));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    rr = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task press(input logic rst);
    @(posedge aclk);
    if (rst) reset_btn <= 1'b1;
    else manual_btn <= 1'b1;
    repeat (8) @(posedge aclk);
    reset_btn <= 1'b0;
    manual_btn <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  task flash_chk;
    logic ph;
    logic [5:0] a, r;
    @(posedge aclk);
    ph = lamps[0].amber;
    a = ph ? 6'h02 : 6'h00;
    r = ph ? 6'h00 : 6'h04;
    chk(lamps, {r, r, a, a});
    repeat (FL * CS) @(posedge aclk);
    chk(lamps[0].amber, !ph);
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    conclude();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, flash_sw, manual_sel, manual_btn, reset_btn} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    sched_sel = '0;
    fault = '0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(lamps, {4{ts_seq_pkg::VR_PR}});
    rd(`TS_CTRL_OFS, st);
    chk(st, 32'h0);
    rd(`TS_IRQ_MASK_OFS, st);
    chk(st, 32'h0);
    rd(8'h10, st);
    chk(rr, `TS_RESP_SLVERR);
    chk(st, 32'h0);
    wr(8'h10, 32'h0);
    chk(rr, `TS_RESP_SLVERR);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h1);
    repeat (2100) @(posedge aclk);
    chk(step_num, 3'h0);
    chk(lamps, {ts_seq_pkg::VR_PG, ts_seq_pkg::VR_PG, ts_seq_pkg::VG_PR, ts_seq_pkg::VG_PR});
    foreach (rows[i]) begin
      sched_sel <= rows[i].sched;
      flash_sw <= rows[i].fsw;
      manual_sel <= rows[i].man;
      wr(`TS_CTRL_OFS, {29'h0, rows[i].ctrl});
      repeat (12) @(posedge aclk);
      rd(`TS_STATUS_OFS, st);
      chk(st[6:3], rows[i].state);
      if (rows[i].state == 4'h4) flash_chk();
      else chk(st[9], 1'b1);
      sched_sel <= 2'h0;
      flash_sw <= 1'b0;
      manual_sel <= 1'b0;
      wr(`TS_CTRL_OFS, 32'h0);
      repeat (12) @(posedge aclk);
      chk(step_num, 3'h0);
    end
    wr(`TS_IRQ_MASK_OFS, 32'h8);
    chk(rr, `TS_RESP_OKAY);
    rd(`TS_IRQ_STAT_OFS, st);
    manual_sel <= 1'b1;
    repeat (12) @(posedge aclk);
    press(1'b0);
    chk(step_num, 3'h0);
    repeat (3300) @(posedge aclk);
    press(1'b0);
    chk(step_num, 3'h1);
    chk(irq, 1'b1);
    rd(`TS_IRQ_STAT_OFS, st);
    chk(st[3], 1'b1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    repeat (400) @(posedge aclk);
    press(1'b0);
    chk(step_num, 3'h2);
    repeat (14400) @(posedge aclk);
    chk(step_num, 3'h2);
    chk(fail_lamp, 1'b0);
    manual_sel <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(fail_lamp, 1'b1);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h8);
    press(1'b1);
    chk(fail_lamp, 1'b0);
    fault <= 4'h5;
    repeat (12) @(posedge aclk);
    chk(gg_lamp, 1'b1);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h8);
    flash_chk();
    press(1'b1);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h8);
    fault <= 4'h0;
    manual_sel <= 1'b0;
    wr(`TS_CTRL_OFS, 32'h3);
    repeat (12) @(posedge aclk);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h8);
    press(1'b1);
    rd(`TS_STATUS_OFS, st);
    chk(st[6:3], 4'h1);
    repeat (2100) @(posedge aclk);
    rd(`TS_STATUS_OFS, st);
    chk(st[8:7], 2'h2);
    chk(step_num, 3'h0);
    conclude();
  end
endmodule
